/* src/swc_pkg.sv */
// control word slot map, opcodes, status and address codes for the slave
// assumes one decoded data bit per link clock, control word in column 0
package swc_pkg;

   localparam int CW_LEN  = 48;
   localparam int SL_PREQ = 0;
   localparam int SL_OP   = 1;
   localparam int SL_DEV  = 4;
   localparam int SL_SSP  = 5;
   localparam int SL_ADDR = 8;
   localparam int SL_RDA  = 23;
   localparam int SL_STC  = 24;
   localparam int SL_PHY  = 32;
   localparam int SL_DATA = 33;
   localparam int SL_DYN  = 41;
   localparam int SL_PAR  = 45;
   localparam int SL_NAK  = 46;
   localparam int SL_ACK  = 47;
   localparam int SL_HI0  = 8;
   localparam int SL_LO0  = 33;
   localparam int DEV_MAX = 11;
   localparam int DEV_HI  = 4;

   localparam logic [2:0] OP_PING    = 3'h0;
   localparam logic [2:0] OP_RD      = 3'h2;
   localparam logic [2:0] OP_WR      = 3'h3;
   localparam logic [7:0] STATIC_SYN = 8'hb1;
   localparam logic [1:0] STAT_OK    = 2'h1;
   localparam logic [1:0] STAT_IRQ   = 2'h2;
   localparam logic [3:0] DEV_GRP0   = 4'hc;
   localparam logic [3:0] DEV_GRP1   = 4'hd;
   localparam logic [3:0] DEV_ALL    = 4'hf;

   typedef enum logic [1:0] {lk_hunt, lk_check, lk_lock} lock_e;

   // first slot of the two-slot status field for a device number
   function automatic int stat_slot(input int dev);
      stat_slot = (dev >= DEV_HI) ? SL_HI0 + 2 * (DEV_MAX - dev) : SL_LO0 + 2 * (3 - dev);
   endfunction : stat_slot

   // field of n slots starting at first, earliest slot is the msb
   function automatic logic [15:0] fld(input logic [CW_LEN-1:0] cw, input int first,
                                       input int n);
      fld = '0;
      for (int i = 0; i < 16; i++)
      begin
         if (i < n)
         begin
            fld = {fld[14:0], cw[first+i]};
         end
      end
   endfunction : fld

endpackage : swc_pkg

/* src/swc_slave.sv */
// control word slave: frame lock, command decode, slot drive, acknowledge
// assumes dat_i is decoded data sampled on clk_link_i; user side on clk_sys_i
`timescale 1ns/10ps

// Contract
// - slot 0 first, msb in earliest slot
// - undriven command decodes as ping
// - owner identity never changes slave handling
// - slave raises ping request on status change
// - opcodes: ping 000, read 010, write 011
// - sync point in a ping passed on as ssp_o
// - slave drives only own status field
// - device address decode incl. groups, broadcast for write only
// - only address bits 14:0 select register
// - addressed slave drives read data slots
// - basic phy only, high phy drops lock
// - check parity over slots 1 to 45, status and read data included
// - answer read and write via ack, parity error via nak
// - unattached and silent until sync found
module swc_slave
   import swc_pkg::*;
#(
   parameter int ROWS = 48,
   parameter int COLS = 2
)(
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   input  wire logic       clk_link_i,
   input  wire logic       dat_i,
   output logic            dat_o,
   output logic            dat_oe_o,
   input  wire logic [3:0] dev_num_i,
   input  wire logic [1:0] grp_en_i,
   input  wire logic       irq_i,
   output logic            attached_o,
   output logic            ssp_o,
   output logic            par_err_o,
   output logic            wr_o,
   output logic            rd_req_o,
   output logic [14:0]     addr_o,
   output logic [7:0]      wdata_o,
   input  wire logic       rd_ack_i,
   input  wire logic [7:0] rd_data_i
);

   localparam int RW = $clog2(ROWS);
   localparam int CWD = (COLS > 1) ? $clog2(COLS) : 1;

   if ((ROWS < CW_LEN) || (COLS < 1))
   begin : g_chk
      $error("swc_slave: ROWS must be at least 48 and COLS at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain reset and crossings in

   logic       lrst_m_r;
   logic       l_rstn_r;
   logic [7:0] lsy_m_r;
   logic [7:0] lsy_r;
   logic       ack_tgl_r;
   logic [7:0] rdat_r;

   always_ff @(posedge clk_link_i)
   begin
      lrst_m_r <= rst_n_i;
      l_rstn_r <= lrst_m_r;
      lsy_m_r  <= {ack_tgl_r, irq_i, grp_en_i, dev_num_i};
      lsy_r    <= lsy_m_r;
   end

   // dev and group straps are quasi-static; a change mid-frame may hit one frame
   wire logic [3:0] own_dev = lsy_r[3:0];
   wire logic [1:0] grp     = lsy_r[5:4];
   wire logic       s_irq   = lsy_r[6];
   wire logic       s_ack   = lsy_r[7];

   ////////////////////////////////////////////////////////////////////////////
   // link domain: slot position and captured control word

   logic [RW-1:0]     row_r;
   logic [CWD-1:0]    col_r;
   logic [CW_LEN-1:0] cw_r;
   logic [CW_LEN-1:0] cw_cur;
   logic              ctl;

   assign ctl = (col_r == '0) && (int'(row_r) < CW_LEN);

   always_comb
   begin
      cw_cur = cw_r;
      if (ctl)
      begin
         cw_cur[row_r] = dat_i;
      end
   end

   wire logic [15:0] f_op  = fld(cw_cur, SL_OP, 3);
   wire logic [15:0] f_dev = fld(cw_cur, SL_DEV, 4);
   wire logic [15:0] f_adr = fld(cw_cur, SL_ADDR, 16);
   wire logic [15:0] f_stc = fld(cw_cur, SL_STC, 8);
   wire logic [15:0] f_dyn = fld(cw_cur, SL_DYN, 4);
   wire logic [15:0] f_wd  = fld(cw_cur, SL_DATA, 8);
   wire logic [2:0]  op    = f_op[2:0];
   wire logic [3:0]  dev   = f_dev[3:0];
   wire logic        perr  = ^cw_cur[SL_PAR:1];
   wire logic [1:0]  stat  = s_irq ? STAT_IRQ : STAT_OK;
   wire integer      spos  = stat_slot(int'(own_dev));
   wire logic        own_ok = int'(own_dev) <= DEV_MAX;

   // owner identity is not visible here: master and monitor frames decode alike
   wire logic hit = (dev == own_dev) || ((dev == DEV_GRP0) && grp[0])
                    || ((dev == DEV_GRP1) && grp[1]) || ((dev == DEV_ALL) && (op == OP_WR));

   ////////////////////////////////////////////////////////////////////////////
   // link domain: lock search, command events, slot drive

   lock_e         st_r, st_nxt;
   logic          sok_r, sok_nxt;
   logic          slip_r, slip_nxt;
   logic [3:0]    dyn_r, dyn_nxt;
   logic          rd_ok_r, rd_ok_nxt;
   logic [7:0]    lrd_r, lrd_nxt;
   logic          ack_seen_r, ack_seen_nxt;
   logic [1:0]    lstat_r, lstat_nxt;
   logic          wr_tgl_r, wr_tgl_nxt;
   logic          rd_tgl_r, rd_tgl_nxt;
   logic          ssp_tgl_r, ssp_tgl_nxt;
   logic          pe_tgl_r, pe_tgl_nxt;
   logic [14:0]   lad_r, lad_nxt;
   logic [7:0]    lwd_r, lwd_nxt;
   logic [RW-1:0] row_nxt;
   logic [CWD-1:0] col_nxt;
   logic          dat_nxt, oe_nxt;
   logic          hold, lk, nctl, preq, nak, ack;
   int            nr;

   always_comb
   begin
      st_nxt = st_r;
      sok_nxt = sok_r;
      dyn_nxt = dyn_r;
      rd_ok_nxt = rd_ok_r;
      lrd_nxt = lrd_r;
      ack_seen_nxt = ack_seen_r;
      lstat_nxt = lstat_r;
      wr_tgl_nxt = wr_tgl_r;
      rd_tgl_nxt = rd_tgl_r;
      ssp_tgl_nxt = ssp_tgl_r;
      pe_tgl_nxt = pe_tgl_r;
      lad_nxt = lad_r;
      lwd_nxt = lwd_r;
      lk = (st_r == lk_lock);
      hold = 1'b0;
      slip_nxt = 1'b0;
      // static sync check; a miss slips the frame grid by one bit and retries
      // the held edge still sees the old sync byte, so it must not check again
      if (ctl && (int'(row_r) == SL_PHY) && !slip_r)
      begin
         sok_nxt = (f_stc[7:0] == STATIC_SYN);
         if (!sok_nxt)
         begin
            hold = 1'b1;
            slip_nxt = 1'b1;
            st_nxt = lk_hunt;
         end
         if (cw_cur[SL_PHY])
         begin
            st_nxt = lk_hunt;
         end
         rd_ok_nxt = lk && (op == OP_RD) && hit && (s_ack != ack_seen_r);
         lrd_nxt = rdat_r;
         ack_seen_nxt = s_ack;
      end
      if (ctl && (int'(row_r) == SL_PAR))
      begin
         dyn_nxt = f_dyn[3:0];
         if (!sok_r)
         begin
            st_nxt = lk_hunt;
         end
         else if (st_r == lk_hunt)
         begin
            st_nxt = lk_check;
         end
         else
         begin
            st_nxt = (f_dyn[3:0] == 4'(dyn_r + 4'h1)) ? lk_lock : lk_hunt;
         end
      end
      if (ctl && (int'(row_r) == SL_RDA) && lk && (op == OP_RD) && hit)
      begin
         rd_tgl_nxt = !rd_tgl_r;
         lad_nxt = f_adr[14:0];
      end
      if (ctl && (int'(row_r) == SL_NAK) && lk)
      begin
         if (perr)
         begin
            pe_tgl_nxt = !pe_tgl_r;
         end
         else if ((op == OP_WR) && hit)
         begin
            wr_tgl_nxt = !wr_tgl_r;
            lad_nxt = f_adr[14:0];
            lwd_nxt = f_wd[7:0];
         end
         else if ((op == OP_PING) && cw_cur[SL_SSP])
         begin
            ssp_tgl_nxt = !ssp_tgl_r;
         end
         if (op == OP_PING)
         begin
            lstat_nxt = stat;
         end
      end
      if (ctl && (int'(row_r) == SL_PREQ))
      begin
         rd_ok_nxt = 1'b0;
      end
      row_nxt = row_r;
      col_nxt = col_r;
      if (!hold)
      begin
         if (int'(col_r) == COLS - 1)
         begin
            col_nxt = '0;
            row_nxt = (int'(row_r) == ROWS - 1) ? '0 : RW'(int'(row_r) + 1);
         end
         else
         begin
            col_nxt = CWD'(int'(col_r) + 1);
         end
      end
      // drive value for the slot that starts at the coming edge
      nr = int'(row_nxt);
      nctl = (col_nxt == '0) && (nr < CW_LEN);
      preq = (stat != lstat_r);
      nak = perr;
      ack = !perr && (((op == OP_WR) && hit) || ((op == OP_RD) && rd_ok_nxt));
      dat_nxt = 1'b0;
      oe_nxt = 1'b0;
      if (nctl && (st_nxt == lk_lock))
      begin
         if (nr == SL_PREQ)
         begin
            dat_nxt = preq;
            oe_nxt = preq;
         end
         else if ((op == OP_PING) && own_ok && ((nr == spos) || (nr == spos + 1)))
         begin
            oe_nxt = 1'b1;
            dat_nxt = (nr == spos) ? stat[1] : stat[0];
         end
         else if (rd_ok_nxt && (nr >= SL_DATA) && (nr < SL_DATA + 8))
         begin
            oe_nxt = 1'b1;
            dat_nxt = lrd_nxt[3'(SL_DATA + 7 - nr)];
         end
         else if (nr == SL_NAK)
         begin
            dat_nxt = nak;
            oe_nxt = nak;
         end
         else if (nr == SL_ACK)
         begin
            dat_nxt = ack;
            oe_nxt = ack;
         end
      end
   end

   always_ff @(posedge clk_link_i)
   begin
      if (!l_rstn_r)
      begin
         st_r <= lk_hunt;
         sok_r <= 1'b0;
         slip_r <= 1'b0;
         dyn_r <= '0;
         rd_ok_r <= 1'b0;
         lrd_r <= '0;
         ack_seen_r <= 1'b0;
         lstat_r <= '0;
         wr_tgl_r <= 1'b0;
         rd_tgl_r <= 1'b0;
         ssp_tgl_r <= 1'b0;
         pe_tgl_r <= 1'b0;
         lad_r <= '0;
         lwd_r <= '0;
         row_r <= '0;
         col_r <= '0;
         cw_r <= '0;
         dat_o <= 1'b0;
         dat_oe_o <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         sok_r <= sok_nxt;
         slip_r <= slip_nxt;
         dyn_r <= dyn_nxt;
         rd_ok_r <= rd_ok_nxt;
         lrd_r <= lrd_nxt;
         ack_seen_r <= ack_seen_nxt;
         lstat_r <= lstat_nxt;
         wr_tgl_r <= wr_tgl_nxt;
         rd_tgl_r <= rd_tgl_nxt;
         ssp_tgl_r <= ssp_tgl_nxt;
         pe_tgl_r <= pe_tgl_nxt;
         lad_r <= lad_nxt;
         lwd_r <= lwd_nxt;
         row_r <= row_nxt;
         col_r <= col_nxt;
         cw_r <= cw_cur;
         dat_o <= dat_nxt;
         dat_oe_o <= oe_nxt;
      end
   end

   wire logic [15:0] r_op = fld(cw_r, SL_OP, 3);

   property p_no_drive_unlock;
      @(posedge clk_link_i) disable iff (!l_rstn_r) (st_r != lk_lock) |-> !dat_oe_o;
   endproperty
   a_no_drive_unlock: assert property (p_no_drive_unlock) else $error("drive while unattached");

   property p_perr_nak;
      @(posedge clk_link_i) disable iff (!l_rstn_r)
         (ctl && (int'(row_r) == SL_NAK) && (st_r == lk_lock) && (^cw_r[SL_PAR:1]))
         |-> (dat_oe_o && dat_o);
   endproperty
   a_perr_nak: assert property (p_perr_nak) else $error("parity error without nak");

   property p_rsvd_noack;
      @(posedge clk_link_i) disable iff (!l_rstn_r)
         (ctl && (int'(row_r) == SL_ACK) && (r_op[2:0] != OP_RD) && (r_op[2:0] != OP_WR))
         |-> !(dat_oe_o && dat_o);
   endproperty
   a_rsvd_noack: assert property (p_rsvd_noack) else $error("ack on ping or reserved");

   property p_ping_stat;
      @(posedge clk_link_i) disable iff (!l_rstn_r)
         (ctl && (st_r == lk_lock) && own_ok && (r_op[2:0] == OP_PING) && $stable(own_dev)
          && (int'(row_r) == spos)) |-> dat_oe_o ##COLS dat_oe_o;
   endproperty
   a_ping_stat: assert property (p_ping_stat) else $error("own status not driven");

   property p_rd_data;
      @(posedge clk_link_i) disable iff (!l_rstn_r)
         (ctl && (int'(row_r) == SL_DATA) && rd_ok_r && (st_r == lk_lock))
         |-> (dat_oe_o && (dat_o == lrd_r[7]));
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data msb not driven");

   property p_slip;
      @(posedge clk_link_i) disable iff (!l_rstn_r)
         (ctl && (int'(row_r) == SL_PHY) && (f_stc[7:0] != STATIC_SYN) && !slip_r)
         |=> ((row_r == $past(row_r)) && (st_r == lk_hunt));
   endproperty
   a_slip: assert property (p_slip) else $error("static sync miss did not slip");

   property p_high_phy;
      @(posedge clk_link_i) disable iff (!l_rstn_r)
         (ctl && (int'(row_r) == SL_PHY) && cw_cur[SL_PHY]) |=> (st_r == lk_hunt);
   endproperty
   a_high_phy: assert property (p_high_phy) else $error("high phy frame kept lock");

   ////////////////////////////////////////////////////////////////////////////
   // system domain: event crossings out, read answer crossing in

   logic [4:0]  ssy_m_r;
   logic [4:0]  ssy_r;
   logic [4:0]  sprv_r;
   logic        wr_nxt, rd_nxt, ssp_nxt, pe_nxt, ack_tgl_nxt;
   logic [14:0] addr_nxt;
   logic [7:0]  wdata_nxt, rdat_nxt;

   always_comb
   begin
      wr_nxt = ssy_r[0] ^ sprv_r[0];
      rd_nxt = ssy_r[1] ^ sprv_r[1];
      ssp_nxt = ssy_r[2] ^ sprv_r[2];
      pe_nxt = ssy_r[3] ^ sprv_r[3];
      // link holds data for a full frame and address for at least 25 slots, so sampling them here is safe
      addr_nxt = (wr_nxt || rd_nxt) ? lad_r : addr_o;
      wdata_nxt = wr_nxt ? lwd_r : wdata_o;
      rdat_nxt = rd_ack_i ? rd_data_i : rdat_r;
      ack_tgl_nxt = rd_ack_i ? !ack_tgl_r : ack_tgl_r;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         ssy_m_r <= '0;
         ssy_r <= '0;
         sprv_r <= '0;
         wr_o <= 1'b0;
         rd_req_o <= 1'b0;
         ssp_o <= 1'b0;
         par_err_o <= 1'b0;
         attached_o <= 1'b0;
         addr_o <= '0;
         wdata_o <= '0;
         rdat_r <= '0;
         ack_tgl_r <= 1'b0;
      end
      else
      begin
         ssy_m_r <= {(st_r == lk_lock), pe_tgl_r, ssp_tgl_r, rd_tgl_r, wr_tgl_r};
         ssy_r <= ssy_m_r;
         sprv_r <= ssy_r;
         wr_o <= wr_nxt;
         rd_req_o <= rd_nxt;
         ssp_o <= ssp_nxt;
         par_err_o <= pe_nxt;
         attached_o <= ssy_r[4];
         addr_o <= addr_nxt;
         wdata_o <= wdata_nxt;
         rdat_r <= rdat_nxt;
         ack_tgl_r <= ack_tgl_nxt;
      end
   end

   property p_ssp_out;
      @(posedge clk_sys_i) disable iff (!rst_n_i) $changed(ssp_tgl_r) |-> ##[1:6] ssp_o;
   endproperty
   a_ssp_out: assert property (p_ssp_out) else $error("sync point not passed on");

   property p_wr_out;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         $changed(wr_tgl_r) |-> ##[1:6] (wr_o && (addr_o == lad_r) && (wdata_o == lwd_r));
   endproperty
   a_wr_out: assert property (p_wr_out) else $error("write not passed on");

endmodule : swc_slave

/* tb/swc_master_model.sv */
// master side of the link: bit clock, control word builder, response capture
// assumes one column per row; undriven slots decode as 0, slave drive is wired-or
`timescale 1ns/10ps
module swc_master_model (
   output logic      clk_link_o,
   output logic      line_o,
   input  wire logic sl_dat_i,
   input  wire logic sl_oe_i
);
   logic       drv_r;
   logic [3:0] dyn_r;

   assign line_o = drv_r | (sl_oe_i & sl_dat_i);

   initial
   begin
      clk_link_o = 1'b0;
      drv_r      = 1'b0;
      dyn_r      = 4'h0;
   end

   function automatic logic [47:0] put(input logic [47:0] cw, input int first, input int n,
                                       input logic [15:0] v);
      for (int i = 0; i < n; i++)
      begin
         cw[first+i] = v[n-1-i];
      end
      return cw;
   endfunction : put

   //////////////////////////////////////////////////////////////////////
   // the bit clock stands still between frames
   task automatic frame(input logic [2:0] op, input logic [3:0] dev, input logic [15:0] addr,
                        input logic [7:0] wd, input logic ssp, input logic phy,
                        input logic flip, output logic [47:0] rsp, output logic oe_seen);
      logic [47:0] cw;
      cw = '0;
      cw = put(cw, 1, 3, {13'h0000, op});
      if (op == 3'h0)
      begin
         // no monitor here: request and release slots stay 0, master keeps ownership
         cw[5] = ssp;
      end
      else
      begin
         cw = put(cw, 4, 4, {12'h000, dev});
         cw = put(cw, 8, 16, addr);
         if (op == 3'h3)
         begin
            cw = put(cw, 33, 8, {8'h00, wd});
         end
      end
      cw = put(cw, 24, 8, 16'h00b1);
      cw[32] = phy;
      cw = put(cw, 41, 4, {12'h000, dyn_r});
      dyn_r = dyn_r + 4'h1;
      oe_seen = 1'b0;
      #3;
      for (int s = 0; s < 48; s++)
      begin
         if (s == 45)
         begin
            // parity covers the line as seen, slave status and read data included
            cw[45] = ^rsp[44:1] ^ flip;
         end
         drv_r = cw[s];
         #40;
         rsp[s] = line_o;
         oe_seen = oe_seen | sl_oe_i;
         clk_link_o = 1'b1;
         #40;
         clk_link_o = 1'b0;
      end
      drv_r = 1'b0;
   endtask : frame
endmodule : swc_master_model

/* tb/swc_slave_tb.sv */
// self-checking bench: slave against the master model, one column per row
// assumes device number 5, member of group 12 only
`timescale 1ns/10ps
module swc_slave_tb;
   logic        clk_sys_i, rst_n_i, irq_i, rd_ack_i;
   logic [7:0]  rd_data_i, wdata_o;
   logic        clk_link, line, dat_o, dat_oe_o, oe;
   logic        attached_o, ssp_o, par_err_o, wr_o, rd_req_o;
   logic [14:0] addr_o;
   logic [47:0] rsp;
   int          bad_count = 0, checks_done = 0, n_wr = 0, n_rd = 0, n_ssp = 0, n_perr = 0;

   swc_slave #(.ROWS(48), .COLS(1)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .clk_link_i(clk_link), .dat_i(line), .dat_o(dat_o), .dat_oe_o(dat_oe_o),
      .dev_num_i(4'h5), .grp_en_i(2'h1), .irq_i(irq_i), .attached_o(attached_o),
      .ssp_o(ssp_o), .par_err_o(par_err_o), .wr_o(wr_o), .rd_req_o(rd_req_o),
      .addr_o(addr_o), .wdata_o(wdata_o), .rd_ack_i(rd_ack_i), .rd_data_i(rd_data_i));
   swc_master_model master (.clk_link_o(clk_link), .line_o(line), .sl_dat_i(dat_o),
      .sl_oe_i(dat_oe_o));

   initial clk_sys_i = 1'b0;
   always #4 clk_sys_i = ~clk_sys_i;

   // user side answers a read request on the next edge
   always @(posedge clk_sys_i)
   begin
      rd_ack_i  <= (rd_req_o === 1'b1);
      rd_data_i <= 8'h3c;
      n_wr      <= n_wr + int'(wr_o === 1'b1);
      n_rd      <= n_rd + int'(rd_req_o === 1'b1);
      n_ssp     <= n_ssp + int'(ssp_o === 1'b1);
      n_perr    <= n_perr + int'(par_err_o === 1'b1);
   end

   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // field of the last response, earliest slot is the msb
   function automatic logic [15:0] got(input int first, input int n);
      logic [15:0] v;
      v = '0;
      for (int i = 0; i < n; i++)
      begin
         v = {v[14:0], rsp[first+i]};
      end
      return v;
   endfunction : got

   task automatic fr(input logic [2:0] op, input logic [3:0] dev = 4'h0,
                     input logic [15:0] addr = 16'h0000, input logic [7:0] wd = 8'h00,
                     input logic ssp = 1'b0, input logic phy = 1'b0, input logic flip = 1'b0);
      master.frame(op, dev, addr, wd, ssp, phy, flip, rsp, oe);
      repeat (10) @(posedge clk_sys_i);
   endtask : fr

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   //////////////////////////////////////////////////////////////////////
   task automatic t_lock();
      fr(3'h0);
      chk("attached early", {15'h0000, attached_o}, 16'h0000);
      chk("drive early", {15'h0000, oe}, 16'h0000);
      // a sync miss slips the grid one bit per frame, so lock comes inside 60 frames
      for (int i = 0; i < 60 && attached_o !== 1'b1; i++)
         fr(3'h0);
      fr(3'h0);
      chk("attached", {15'h0000, attached_o}, 16'h0001);
      chk("own status", got(20, 2), 16'h0001);
      chk("other status", got(18, 2), 16'h0000);
      $display("test lock done");
   endtask : t_lock

   task automatic t_write();
      logic [23:0] devs;
      logic [5:0]  hit;
      int          n0;
      devs = 24'hfe_dc65;
      hit  = 6'h25;
      for (int i = 0; i < 6; i++)
      begin
         n0 = n_wr;
         fr(3'h3, devs[4*i+:4], 16'h8123 + 16'(i), 8'ha5);
         chk("write ack", {15'h0000, rsp[47]}, {15'h0000, hit[i]});
         chk("write nak", {15'h0000, rsp[46]}, 16'h0000);
         chk("write pulses", 16'(n_wr - n0), {15'h0000, hit[i]});
         if (hit[i])
         begin
            chk("write addr", {1'b0, addr_o}, 16'h0123 + 16'(i));
            chk("write data", {8'h00, wdata_o}, 16'h00a5);
         end
      end
      $display("test write done");
   endtask : t_write

   task automatic t_read_parity();
      int n0, p0;
      n0 = n_wr;
      p0 = n_perr;
      fr(3'h3, 4'h5, 16'h0011, 8'h5a, 1'b0, 1'b0, 1'b1);
      chk("bad parity nak", got(46, 2), 16'h0002);
      chk("bad parity write", 16'(n_wr - n0), 16'h0000);
      chk("parity error", 16'(n_perr - p0), 16'h0001);
      n0 = n_rd;
      fr(3'h2, 4'h5, 16'hc042);
      chk("read request", 16'(n_rd - n0), 16'h0001);
      chk("read addr", {1'b0, addr_o}, 16'h4042);
      chk("read data", got(33, 8), 16'h003c);
      chk("read answer", got(46, 2), 16'h0001);
      $display("test read and parity done");
   endtask : t_read_parity

   task automatic t_ping();
      int n0;
      for (int op = 1; op < 8; op++)
      begin
         if (op != 2 && op != 3)
         begin
            fr(3'(op), 4'h5, 16'h0020);
            chk("reserved answer", got(46, 2), 16'h0000);
         end
      end
      n0 = n_ssp;
      fr(3'h0, 4'h0, 16'h0000, 8'h00, 1'b1);
      chk("sync point", 16'(n_ssp - n0), 16'h0001);
      chk("ping answer", got(46, 2), 16'h0000);
      @(posedge clk_sys_i) irq_i <= 1'b1;
      fr(3'h3, 4'h6);
      fr(3'h0);
      chk("ping request", {15'h0000, rsp[0]}, 16'h0001);
      chk("irq status", got(20, 2), 16'h0002);
      fr(3'h0);
      chk("request cleared", {15'h0000, rsp[0]}, 16'h0000);
      $display("test ping done");
   endtask : t_ping

   task automatic t_phy();
      fr(3'h0, 4'h0, 16'h0000, 8'h00, 1'b0, 1'b1);
      chk("high phy drop", {15'h0000, attached_o}, 16'h0000);
      $display("test phy done");
   endtask : t_phy

   //////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n_i   = 1'b0;
      irq_i     = 1'b0;
      rd_ack_i  = 1'b0;
      rd_data_i = 8'h00;
      fork
         begin
            repeat (12) @(posedge clk_sys_i);
            rst_n_i <= 1'b1;
         end
         fr(3'h0);
      join
      t_lock();
      t_write();
      t_read_parity();
      t_ping();
      t_phy();
      give_verdict();
   end

   initial
   begin
      #400_000;
      bad_count++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule : swc_slave_tb
